//--- design/cgw_gateway.sv
// Gateway object engine: FIFO gateway pointer and shared gateway toggling
// Summary of operation
// - FIFO mode: pointer picks element, then advances
// - Copied element transmit request follows autosend
// - FIFO elements never forward remote frames
// - Shared mode code makes one toggling object
// - Node select zero: A source, one: B
// - Source data with autosend: move, store, send
// - After data sent: clear flags, maybe return
// - Remote, no forwarding: answer with stored data
// - Remote with forwarding: move to source side
// - Forwarded remote frame sent without CPU
// - Source data without autosend: move, wait
// - Frames on inactive side lost, no flag
// - Message lost acts as update lock on destination side only
// - Remote sent: clear request and pending, set interrupt if enabled, no move
`timescale 1ns/1ps
module cgw_gateway
    import cgw_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input cgw_pkg::cgw_rx_t rx_i,
    input cgw_pkg::cgw_txdone_t txdone_i,
    output cgw_pkg::cgw_tx_t tx_o,
    output cgw_pkg::cgw_copy_t copy_o
);
    import cgw_pkg::*;

    cgw_state_t q; // Registered state
    cgw_state_t d; // Next state
    logic shared_m; // Shared gateway mode active
    logic fifo_m; // FIFO gateway mode active
    logic rx_here; // Frame seen by the node the object sits on
    logic data_src; // Data frame at source side
    logic rmt_dst; // Remote frame at destination side
    logic done_ok; // Our own transmission finished
    logic lock_eff; // Update lock, including message-lost reuse
    logic [4:0] fmask; // FIFO index mask

    // Event decode, all from same-clock logic, so no synchronisers
    always_comb
    begin
        shared_m = (q.mode == CGW_MODE_SHARED);
        fifo_m = (q.mode[2:1] == CGW_MODE_FIFO_HI);
        // Only the current node is looked at; the other side is blind
        rx_here = rx_i.valid && (rx_i.node == q.node);
        data_src = rx_here && !rx_i.remote && !q.dir;
        rmt_dst = rx_here && rx_i.remote && q.dir;
        done_ok = txdone_i.valid && (q.txst == CGW_TX_BUSY)
            && (txdone_i.node == q.tx.node)
            && (txdone_i.remote == q.tx.remote);
        // On the transmit side the message-lost flag doubles as a lock
        lock_eff = q.flags[CGW_F_LOCK]
            || (q.dir && q.flags[CGW_F_MLST]);
        fmask = q.flen - 5'h01;
    end

    // Next-state logic: CPU access first, hardware transitions on top
    always_comb
    begin
        d = q;
        d.tx.valid = 1'b0;
        d.copy.valid = 1'b0;
        d.rdata = CGW_UNMAPPED;
        // CPU writes; hardware below overrides, so a hardware update wins over a CPU write
        if (wr_i)
        begin
            case (addr_i)
                CGW_CTRL_OFS:
                begin
                    d.mode = wdata_i[CGW_MODE_POS +: 3];
                    d.node = wdata_i[CGW_NODE_POS];
                    d.dir = wdata_i[CGW_DIR_POS];
                    d.autosend = wdata_i[CGW_ASND_POS];
                    d.rfe = wdata_i[CGW_RFE_POS];
                    d.remote_monitor_bit = wdata_i[CGW_RMM_POS];
                    d.identifier_copy = wdata_i[CGW_IDC_POS];
                    d.length_code_copy = wdata_i[CGW_LENGTH_CODE_COPY_POS];
                    d.flen = wdata_i[CGW_FLEN_POS +: 5];
                    d.ptr = wdata_i[CGW_PTR_POS +: 5];
                    d.receive_irq_enable = wdata_i[CGW_RECEIVE_IRQ_ENABLE_POS];
                    d.transmit_irq_enable = wdata_i[CGW_TRANSMIT_IRQ_ENABLE_POS];
                end
                CGW_FLAG_OFS:
                begin
                    // Two-bit codes: set, reset, anything else keeps
                    for (int i = 0; i < CGW_NFLAGS; i++)
                    begin
                        if (wdata_i[2*i +: 2] == CGW_CODE_SET)
                            d.flags[i] = 1'b1;
                        else if (wdata_i[2*i +: 2] == CGW_CODE_RST)
                            d.flags[i] = 1'b0;
                    end
                end
                CGW_ID_OFS: d.frame.id = wdata_i[28:0];
                CGW_DLC_OFS: d.frame.dlc = wdata_i[3:0];
                CGW_DLO_OFS: d.frame.data[31:0] = wdata_i;
                CGW_DHI_OFS: d.frame.data[63:32] = wdata_i;
                default: ; // Unmapped writes are dropped
            endcase
        end
        // Reads return the pre-transition image, never a half update
        if (rd_i)
        begin
            case (addr_i)
                CGW_CTRL_OFS:
                begin
                    d.rdata = 32'h0000_0000;
                    d.rdata[CGW_MODE_POS +: 3] = q.mode;
                    d.rdata[CGW_NODE_POS] = q.node;
                    d.rdata[CGW_DIR_POS] = q.dir;
                    d.rdata[CGW_ASND_POS] = q.autosend;
                    d.rdata[CGW_RFE_POS] = q.rfe;
                    d.rdata[CGW_RMM_POS] = q.remote_monitor_bit;
                    d.rdata[CGW_IDC_POS] = q.identifier_copy;
                    d.rdata[CGW_LENGTH_CODE_COPY_POS] = q.length_code_copy;
                    d.rdata[CGW_FLEN_POS +: 5] = q.flen;
                    d.rdata[CGW_PTR_POS +: 5] = q.ptr;
                    d.rdata[CGW_RECEIVE_IRQ_ENABLE_POS] = q.receive_irq_enable;
                    d.rdata[CGW_TRANSMIT_IRQ_ENABLE_POS] = q.transmit_irq_enable;
                end
                CGW_FLAG_OFS:
                begin
                    d.rdata = 32'h0000_0000;
                    for (int i = 0; i < CGW_NFLAGS; i++)
                        d.rdata[2*i +: 2] = q.flags[i] ? CGW_CODE_SET
                            : CGW_CODE_RST;
                end
                CGW_ID_OFS: d.rdata = {3'h0, q.frame.id};
                CGW_DLC_OFS: d.rdata = {28'h0000000, q.frame.dlc};
                CGW_DLO_OFS: d.rdata = q.frame.data[31:0];
                CGW_DHI_OFS: d.rdata = q.frame.data[63:32];
                default: d.rdata = CGW_UNMAPPED;
            endcase
        end
        // FIFO gateway: copy into the element the pointer names
        if (fifo_m && rx_here && !rx_i.remote)
        begin
            d.copy.valid = 1'b1;
            d.copy.element = q.ptr;
            d.copy.set_transmit_request = q.autosend;
            d.copy.copy_id = q.identifier_copy;
            d.copy.copy_dlc = q.length_code_copy;
            d.copy.frame = rx_i.frame;
            // Wrap inside the aligned block; relies on software layout
            d.ptr = (q.ptr & ~fmask) | ((q.ptr + 5'h01) & fmask);
        end
        // Shared gateway transitions, each applied in a single cycle
        if (shared_m)
        begin
            if (data_src)
            begin
                // Transitions 1 and 7: commute to the destination
                if (q.flags[CGW_F_NDAT])
                    d.flags[CGW_F_MLST] = 1'b1;
                d.node = !q.node;
                d.dir = 1'b1;
                d.frame = rx_i.frame;
                d.flags[CGW_F_TRANSMIT_REQUEST] = q.autosend;
                d.flags[CGW_F_NDAT] = 1'b1;
                d.flags[CGW_F_RPND] = 1'b0;
                if (q.receive_irq_enable)
                    d.flags[CGW_F_IPND] = 1'b1;
            end
            else if (rmt_dst && !q.rfe)
            begin
                // Transition 4: answer locally with stored data
                d.flags[CGW_F_TRANSMIT_REQUEST] = 1'b1;
                d.flags[CGW_F_RPND] = 1'b1;
                d.flags[CGW_F_NDAT] = 1'b0;
                if (q.remote_monitor_bit)
                begin
                    d.frame.id = rx_i.frame.id;
                    d.frame.dlc = rx_i.frame.dlc;
                end
                if (q.receive_irq_enable)
                    d.flags[CGW_F_IPND] = 1'b1;
            end
            else if (rmt_dst)
            begin
                // Transition 5: become a source-side receive object
                d.node = !q.node;
                d.dir = 1'b0;
                d.flags[CGW_F_TRANSMIT_REQUEST] = 1'b1;
                d.flags[CGW_F_RPND] = 1'b1;
                if (q.remote_monitor_bit)
                begin
                    d.frame.id = rx_i.frame.id;
                    d.frame.dlc = rx_i.frame.dlc;
                end
                if (q.receive_irq_enable)
                    d.flags[CGW_F_IPND] = 1'b1;
            end
            if (done_ok && !q.tx.remote)
            begin
                // Transitions 2 and 3: data frame left the destination
                d.flags[CGW_F_TRANSMIT_REQUEST] = 1'b0;
                d.flags[CGW_F_RPND] = 1'b0;
                d.flags[CGW_F_NDAT] = 1'b0;
                if (!q.rfe)
                begin
                    d.node = !q.node;
                    d.dir = 1'b0;
                end
                if (q.transmit_irq_enable)
                    d.flags[CGW_F_IPND] = 1'b1;
            end
            else if (done_ok)
            begin
                // Transition 6; a data frame landing now keeps its request
                if (!data_src)
                    d.flags[CGW_F_TRANSMIT_REQUEST] = 1'b0;
                d.flags[CGW_F_RPND] = 1'b0;
                if (q.transmit_irq_enable)
                    d.flags[CGW_F_IPND] = 1'b1;
            end
        end
        // Transmit engine: one frame in flight per object
        case (q.txst)
            CGW_TX_IDLE:
            begin
                // Source side sends remote, destination side sends data
                if (shared_m && q.flags[CGW_F_TRANSMIT_REQUEST]
                    && (!q.dir || !lock_eff))
                begin
                    d.tx.valid = 1'b1;
                    d.tx.node = q.node;
                    d.tx.remote = !q.dir;
                    d.tx.frame = q.frame;
                    d.txst = CGW_TX_BUSY;
                end
            end
            CGW_TX_BUSY:
            begin
                // Leaving shared mode abandons the wait for completion
                if (done_ok || !shared_m)
                    d.txst = CGW_TX_IDLE;
            end
            default: d.txst = CGW_TX_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            q <= '0;
            q.mode <= CGW_MODE_STD;
            q.flen <= CGW_FLEN_RST;
            q.ptr <= CGW_PTR_RST;
            q.txst <= CGW_TX_IDLE;
        end
        else
            q <= d;
    end

    // Outputs straight from the state flops
    assign rdata_o = q.rdata;
    assign tx_o = q.tx;
    assign copy_o = q.copy;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    shared_move_dst_a: assert property (
        shared_m && data_src && q.autosend |=> q.dir && q.node != $past(q.node)
        && q.flags[CGW_F_TRANSMIT_REQUEST] && q.flags[CGW_F_NDAT] && !q.flags[CGW_F_RPND])
        else $error("data frame did not move object to destination");
    data_return_a: assert property (
        shared_m && done_ok && !q.tx.remote && !q.rfe
        |=> !q.dir && !q.flags[CGW_F_TRANSMIT_REQUEST] && !q.flags[CGW_F_NDAT])
        else $error("object did not return to source after data sent");
    data_stay_a: assert property (
        shared_m && done_ok && !q.tx.remote && q.rfe && !rx_i.valid
        |=> q.dir && $stable(q.node))
        else $error("object left destination with forwarding on");
    remote_answer_a: assert property (
        shared_m && rmt_dst && !q.rfe && !done_ok |=> q.flags[CGW_F_TRANSMIT_REQUEST]
        && q.flags[CGW_F_RPND] && !q.flags[CGW_F_NDAT] && q.dir)
        else $error("remote frame not answered locally");
    remote_fwd_a: assert property (
        shared_m && rmt_dst && q.rfe && !done_ok
        |=> !q.dir && q.flags[CGW_F_TRANSMIT_REQUEST] && q.node != $past(q.node))
        else $error("remote frame not forwarded to source");
    remote_sent_a: assert property (
        shared_m && done_ok && q.tx.remote && !rx_i.valid && !wr_i
        |=> !q.flags[CGW_F_TRANSMIT_REQUEST] && !q.flags[CGW_F_RPND] && $stable(q.dir)
        && $stable(q.node))
        else $error("remote completion changed the wrong fields");
    blind_side_a: assert property (
        shared_m && rx_i.valid && rx_i.node != q.node && !wr_i
        |=> $stable(q.flags[CGW_F_MLST]) && $stable(q.frame))
        else $error("frame on inactive side was noticed");
    lost_lock_a: assert property (
        shared_m && q.dir && q.flags[CGW_F_MLST] |=> !(q.tx.valid && !q.tx.remote))
        else $error("data sent while message lost acts as lock");
    fifo_copy_a: assert property (
        fifo_m && rx_here && !rx_i.remote |=> copy_o.valid
        && copy_o.element == $past(q.ptr) && copy_o.set_transmit_request == $past(q.autosend))
        else $error("FIFO copy did not follow pointer or autosend");
    fifo_no_fwd_a: assert property (
        fifo_m && q.txst == CGW_TX_IDLE |=> !tx_o.valid)
        else $error("FIFO gateway forwarded a frame");
endmodule // cgw_gateway

//--- include/cgw_pkg.sv
// Package for the message-object gateway: map, codes, carriers and state
package cgw_pkg;
    // Register byte offsets
    localparam logic [7:0] CGW_CTRL_OFS = 8'h00;
    localparam logic [7:0] CGW_FLAG_OFS = 8'h04;
    localparam logic [7:0] CGW_ID_OFS = 8'h08;
    localparam logic [7:0] CGW_DLC_OFS = 8'h0C;
    localparam logic [7:0] CGW_DLO_OFS = 8'h10;
    localparam logic [7:0] CGW_DHI_OFS = 8'h14;
    // Control register field positions
    localparam int CGW_MODE_POS = 0;
    localparam int CGW_NODE_POS = 3;
    localparam int CGW_DIR_POS = 4;
    localparam int CGW_ASND_POS = 5;
    localparam int CGW_RFE_POS = 6;
    localparam int CGW_RMM_POS = 7;
    localparam int CGW_IDC_POS = 8;
    localparam int CGW_LENGTH_CODE_COPY_POS = 9;
    localparam int CGW_FLEN_POS = 10;
    localparam int CGW_PTR_POS = 16;
    localparam int CGW_RECEIVE_IRQ_ENABLE_POS = 21;
    localparam int CGW_TRANSMIT_IRQ_ENABLE_POS = 22;
    // Flag indices inside the flag register, two bits per flag
    localparam int CGW_NFLAGS = 6;
    localparam int CGW_F_TRANSMIT_REQUEST = 0;
    localparam int CGW_F_RPND = 1;
    localparam int CGW_F_NDAT = 2;
    localparam int CGW_F_MLST = 3;
    localparam int CGW_F_IPND = 4;
    localparam int CGW_F_LOCK = 5;
    // Two-bit flag codes: set, reset
    localparam logic [1:0] CGW_CODE_SET = 2'h2;
    localparam logic [1:0] CGW_CODE_RST = 2'h1;
    // Message mode codes
    localparam logic [2:0] CGW_MODE_STD = 3'h0;
    localparam logic [2:0] CGW_MODE_SHARED = 3'h5;
    localparam logic [1:0] CGW_MODE_FIFO_HI = 2'h1;
    // Reset values
    localparam logic [4:0] CGW_PTR_RST = 5'h00;
    localparam logic [4:0] CGW_FLEN_RST = 5'h00;
    localparam logic [31:0] CGW_UNMAPPED = 32'h0000_0000;

    // One CAN frame payload
    typedef struct packed {
        logic [28:0] id;
        logic [3:0] dlc;
        logic [63:0] data;
    } cgw_frame_t;

    // Matching frame received by a node (pulse)
    typedef struct packed {
        logic valid;
        logic node;
        logic remote;
        cgw_frame_t frame;
    } cgw_rx_t;

    // Frame finished on a bus (pulse)
    typedef struct packed {
        logic valid;
        logic node;
        logic remote;
    } cgw_txdone_t;

    // Transmit order to a node (pulse, fields held)
    typedef struct packed {
        logic valid;
        logic node;
        logic remote;
        cgw_frame_t frame;
    } cgw_tx_t;

    // Copy order into a FIFO element (pulse, fields held)
    typedef struct packed {
        logic valid;
        logic [4:0] element;
        logic set_transmit_request;
        logic copy_id;
        logic copy_dlc;
        cgw_frame_t frame;
    } cgw_copy_t;

    // Transmit engine states, one-hot
    typedef enum logic [1:0] {
        CGW_TX_IDLE = 2'b01,
        CGW_TX_BUSY = 2'b10
    } cgw_txst_t;

    // Whole state of the gateway object
    typedef struct packed {
        logic [2:0] mode;
        logic node;
        logic dir;
        logic autosend;
        logic rfe;
        logic remote_monitor_bit;
        logic identifier_copy;
        logic length_code_copy;
        logic [4:0] flen;
        logic [4:0] ptr;
        logic receive_irq_enable;
        logic transmit_irq_enable;
        logic [CGW_NFLAGS-1:0] flags;
        cgw_frame_t frame;
        cgw_txst_t txst;
        cgw_tx_t tx;
        cgw_copy_t copy;
        logic [31:0] rdata;
    } cgw_state_t;
endpackage

//--- test/cgw_bus_model.sv
// Far-side model of both buses: ends each ordered frame after a delay
`timescale 1ns/1ps
module cgw_bus_model
    import cgw_pkg::*;
(
    input wire logic mclk_i,
    input wire logic srst_i,
    input wire logic [4:0] dly_i,
    input cgw_pkg::cgw_tx_t tx_i,
    output cgw_pkg::cgw_txdone_t txdone_o
);
    logic busy_q; // A frame is on the wire
    logic [4:0] cnt_q; // Cycles left until the frame ends
    cgw_txdone_t pend_q; // Node and kind of the frame on the wire

    // End of frame is reported on the node and with the kind ordered; a
    // zero delay still takes one cycle, since a frame always takes time
    always_ff @(posedge mclk_i)
    begin
        txdone_o <= '0;
        if (srst_i)
        begin
            busy_q <= 1'h0;
            cnt_q <= 5'h00;
            pend_q <= '0;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q - 5'h01;
            if (cnt_q <= 5'h01)
            begin
                busy_q <= 1'h0;
                txdone_o <= pend_q;
            end
        end
        else if (tx_i.valid)
        begin
            busy_q <= 1'h1;
            cnt_q <= dly_i;
            pend_q <= {1'h1, tx_i.node, tx_i.remote};
        end
    end
endmodule // cgw_bus_model

//--- test/test_can_gateway_fifo_shared.sv
// Self-checking bench for the gateway object engine
`timescale 1ns/1ps
module test_can_gateway_fifo_shared;
    import cgw_pkg::*;
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
n_mismatch++; $display("BAD %s exp %h got %h", nm, e, g); end end
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } cgw_row_t;
    logic mclk = 1'h0; // Bus clock, 40 MHz
    logic srst = 1'h1; // Held for the first two edges
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic [31:0] rdata;
    logic [4:0] dly = 5'h14; // Frame length on the far side
    cgw_rx_t rx = '0;
    cgw_txdone_t done;
    cgw_tx_t tx;
    cgw_copy_t cp;
    cgw_tx_t last_tx; // Last transmit order seen
    cgw_copy_t last_cp; // Last copy order seen
    int n_tx = 0;
    int n_done = 0;
    int n_cp = 0;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [31:0] v;
    cgw_row_t rows [6];
    cgw_frame_t f0 = {29'h0ABC_1234, 4'h8, 64'h1122_3344_5566_7788};
    cgw_frame_t f1 = {29'h0000_0321, 4'h2, 64'hFFEE_DDCC_BBAA_9988};

    always #12.5 mclk = ~mclk;

    cgw_gateway cgw_gateway_i (.mclk_i(mclk), .srst_i(srst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rx_i(rx),
        .txdone_i(done), .tx_o(tx), .copy_o(cp));
    cgw_bus_model cgw_bus_model_i (.mclk_i(mclk), .srst_i(srst),
        .dly_i(dly), .tx_i(tx), .txdone_o(done));

    // Pulses are counted at the edge that ends them; also cuts a hang
    always @(posedge mclk)
    begin
        cycles++;
        if (tx.valid === 1'h1)
        begin
            n_tx++;
            last_tx = tx;
        end
        if (cp.valid === 1'h1)
        begin
            n_cp++;
            last_cp = cp;
        end
        if (done.valid === 1'h1)
            n_done++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    // Control word: identifier and length copies only outside shared mode
    function automatic logic [31:0] ctl(input logic [2:0] m, input logic n,
        input logic d, input logic a, input logic r, input logic [4:0] l,
        input logic [4:0] p);
        ctl = {9'h0, 2'h3, p, 1'h0, l, ~m[2], ~m[2], 1'h1, r, a, d, n, m};
    endfunction

    // Flag image, one two-bit code a flag
    function automatic logic [31:0] fl(input logic [5:0] s);
        fl = 32'h0;
        for (int k = 0; k < CGW_NFLAGS; k++)
            fl[2*k +: 2] = s[k] ? CGW_CODE_SET : CGW_CODE_RST;
    endfunction

    task automatic wrr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'h0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input string nm);
        @(posedge mclk);
        rd <= 1'h1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'h0;
        #1 v = rdata;
        `CHK(nm, e, v)
    endtask

    task automatic send(input logic n, input logic r, input cgw_frame_t f);
        @(posedge mclk);
        rx <= {1'h1, n, r, f};
        @(posedge mclk);
        rx.valid <= 1'h0;
    endtask

    // Bounded wait on a pulse count, then let the state settle
    task automatic wait_for(ref int c, input int t, input string nm);
        for (int k = 0; k < 60 && c < t; k++)
        begin
            @(posedge mclk);
            #1;
        end
        `CHK(nm, 1'h1, 1'(c >= t))
        repeat (2) @(posedge mclk);
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        rows = '{'{CGW_CTRL_OFS, ctl(3'h0, 1, 1, 1, 1, 5'h10, 5'h1F), 32'h0},
            '{CGW_ID_OFS, 32'h1FFF_FFFF, 32'h1FFF_FFFF},
            '{CGW_DLC_OFS, 32'h0000_000F, 32'h0000_000F},
            '{CGW_DLO_OFS, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
            '{CGW_DHI_OFS, 32'h0123_4567, 32'h0123_4567},
            '{8'h18, 32'hFFFF_FFFF, CGW_UNMAPPED}};
        rows[0].e = rows[0].d;
        repeat (2) @(posedge mclk);
        srst <= 1'h0;
        rchk(CGW_CTRL_OFS, 32'h0, "ctrl reset");
        rchk(CGW_FLAG_OFS, fl(6'h00), "flags reset");
        $display("test reset done");
        foreach (rows[i])
        begin
            wrr(rows[i].a, rows[i].d);
            rchk(rows[i].a, rows[i].e, "reg");
        end
        @(posedge mclk);
        #1 `CHK("rdata idle", 32'h0, rdata)
        $display("test registers done");
        // Aligned four-element FIFO based at 8
        wrr(CGW_CTRL_OFS, ctl(3'h2, 0, 0, 1, 0, 5'h04, 5'h08));
        for (int k = 0; k < 5; k++)
        begin
            send(1'h0, 1'h0, {29'(k), 4'h8, 64'(k)});
            wait_for(n_cp, k + 1, "copy");
            `CHK("element", 5'(8 + k % 4), last_cp.element)
            `CHK("transmit_request", 1'h1, last_cp.set_transmit_request)
            `CHK("cps", 2'h3, {last_cp.copy_id, last_cp.copy_dlc})
            `CHK("frame", {29'(k), 4'h8, 64'(k)}, last_cp.frame)
        end
        rchk(CGW_CTRL_OFS, ctl(3'h2, 0, 0, 1, 0, 5'h04, 5'h09),
            "ptr");
        // Remote frames at a FIFO are left to software
        send(1'h0, 1'h1, f1);
        send(1'h1, 1'h1, f1);
        repeat (8) @(posedge mclk);
        `CHK("no fwd", 32'h5, 32'(n_cp + n_tx))
        wrr(CGW_CTRL_OFS, ctl(3'h2, 0, 0, 0, 0, 5'h04, 5'h09));
        send(1'h0, 1'h0, f0);
        wait_for(n_cp, 6, "copy");
        `CHK("elem", 5'h09, last_cp.element)
        `CHK("no transmit_request", 1'h0, last_cp.set_transmit_request)
        $display("test fifo done");
        // Complementary node selects form a two-way pair
        for (int n = 0; n < 2; n++)
        begin
            // Own number 3, length and copies clear
            wrr(CGW_CTRL_OFS, ctl(3'h5, 1'(n), 0, 1, 0, 5'h00, 5'h03));
            wrr(CGW_FLAG_OFS, fl(6'h00));
            send(1'(n), 1'h0, f0);
            wait_for(n_tx, n_done + 1, "data tx");
            `CHK("node", ~1'(n), last_tx.node)
            `CHK("kind", 1'h0, last_tx.remote)
            `CHK("frame", f0, last_tx.frame)
            rchk(CGW_CTRL_OFS, ctl(3'h5, ~1'(n), 1, 1, 0, 0, 3),
                "c1");
            rchk(CGW_FLAG_OFS, fl(6'b010101), "f1");
            send(1'(n), 1'h0, f1);
            wait_for(n_done, n_tx, "done");
            rchk(CGW_CTRL_OFS, ctl(3'h5, 1'(n), 0, 1, 0, 0, 3),
                "c2");
            rchk(CGW_FLAG_OFS, fl(6'b010000), "f2");
            rchk(CGW_ID_OFS, {3'h0, f0.id}, "lost");
        end
        $display("test transitions 1 2 done");
        wrr(CGW_CTRL_OFS, ctl(3'h5, 0, 0, 0, 0, 5'h00, 5'h03));
        wrr(CGW_FLAG_OFS, fl(6'h00));
        send(1'h0, 1'h0, f0);
        repeat (8) @(posedge mclk);
        `CHK("held", n_done, n_tx)
        rchk(CGW_CTRL_OFS, ctl(3'h5, 1, 1, 0, 0, 0, 3), "c7");
        rchk(CGW_FLAG_OFS, fl(6'b010100), "f7");
        send(1'h1, 1'h1, f1);
        wait_for(n_tx, n_done + 1, "answer");
        `CHK("ans", {1'h1, 1'h0}, {last_tx.node, last_tx.remote})
        `CHK("afr", {f1.id, f1.dlc, f0.data}, last_tx.frame)
        rchk(CGW_FLAG_OFS, fl(6'b010011), "f4");
        wait_for(n_done, n_tx, "done");
        rchk(CGW_CTRL_OFS, ctl(3'h5, 0, 0, 0, 0, 0, 3), "c2");
        $display("test transitions 7 4 done");
        dly <= 5'h01;
        wrr(CGW_CTRL_OFS, ctl(3'h5, 1, 1, 1, 1, 5'h00, 5'h03));
        wrr(CGW_FLAG_OFS, fl(6'h00));
        send(1'h1, 1'h1, f1);
        wait_for(n_tx, n_done + 1, "remote");
        `CHK("rem", {1'h0, 1'h1}, {last_tx.node, last_tx.remote})
        wait_for(n_done, n_tx, "done");
        rchk(CGW_CTRL_OFS, ctl(3'h5, 0, 0, 1, 1, 0, 3), "c6");
        rchk(CGW_FLAG_OFS, fl(6'b010000), "f6");
        send(1'h0, 1'h0, f0);
        wait_for(n_tx, n_done + 1, "data tx");
        `CHK("dat", {1'h1, 1'h0}, {last_tx.node, last_tx.remote})
        wait_for(n_done, n_tx, "done");
        rchk(CGW_CTRL_OFS, ctl(3'h5, 1, 1, 1, 1, 0, 3), "c3");
        rchk(CGW_FLAG_OFS, fl(6'b010000), "f3");
        $display("test transitions 5 6 1 3 done");
        wrr(CGW_CTRL_OFS, ctl(3'h5, 0, 0, 1, 0, 5'h00, 5'h03));
        wrr(CGW_FLAG_OFS, fl(6'b001000));
        send(1'h0, 1'h0, f0);
        repeat (8) @(posedge mclk);
        `CHK("locked", n_done, n_tx)
        rchk(CGW_CTRL_OFS, ctl(3'h5, 1, 1, 1, 0, 0, 3), "cl");
        wrr(CGW_FLAG_OFS, 32'h0000_0040);
        wait_for(n_tx, n_done + 1, "unlock");
        wait_for(n_done, n_tx, "done");
        $display("test lock done");
        srst <= 1'h1;
        repeat (2) @(posedge mclk);
        srst <= 1'h0;
        rchk(CGW_CTRL_OFS, 32'h0, "ctrl rerst");
        rchk(CGW_FLAG_OFS, fl(6'h00), "flags rerst");
        $display("test second reset done");
        give_verdict();
    end
endmodule // test_can_gateway_fifo_shared
